/* File: design/dsad_pkg.sv */
// Constants, types and carriers shared by the data space address decoder.
// Assumes a single core clock and an 8-bit data path with 16-bit data addresses.
package dsad_pkg;

	localparam int unsigned DATA_W       = 8;
	localparam int unsigned ADDR_W       = 16;
	localparam int unsigned PC_W         = 12;
	localparam int unsigned SRAM_BYTES   = 512;
	localparam int unsigned SRAM_AW      = 9;
	localparam int unsigned RF_WORDS     = 32;

	localparam logic [15:0] RF_BASE      = 16'h0000;
	localparam logic [15:0] STDIO_BASE   = 16'h0020;
	localparam logic [15:0] EXTIO_BASE   = 16'h0060;
	localparam logic [15:0] SRAM_BASE    = 16'h0100;
	localparam logic [15:0] DATA_END     = 16'h0300;
	localparam logic [15:0] IO_DATA_OFS  = 16'h0020;

	localparam logic [5:0]  BIT_IO_LAST  = 6'h1F;
	localparam logic [5:0]  DISP_MAX     = 6'h3F;

	localparam logic [5:0]  IO_SCRATCH_ZERO = 6'h1C;
	localparam logic [5:0]  IO_SCRATCH_ONE  = 6'h1D;
	localparam logic [5:0]  IO_SCRATCH_TWO  = 6'h1E;
	localparam logic [5:0]  IO_EVENT_FLAGS  = 6'h1F;

	localparam logic [7:0]  SCRATCH_RESET   = 8'h00;
	localparam logic [7:0]  FLAGS_RESET     = 8'h00;
	localparam logic [7:0]  RF_RESET        = 8'h00;
	localparam logic [11:0] PC_RESET        = 12'h000;

	localparam logic [4:0]  PTR_X_LO     = 5'h1A;
	localparam logic [4:0]  PTR_Y_LO     = 5'h1C;
	localparam logic [4:0]  PTR_Z_LO     = 5'h1E;

	typedef enum logic [2:0] {
		KIND_LOAD,
		KIND_STORE,
		KIND_IO_IN,
		KIND_IO_OUT,
		KIND_BIT_SET,
		KIND_BIT_CLEAR,
		KIND_SKIP_IF_SET,
		KIND_SKIP_IF_CLEAR
	} dsad_kind_e;

	typedef enum logic [2:0] {
		MODE_DIRECT,
		MODE_INDIRECT,
		MODE_DISP,
		MODE_PREDEC,
		MODE_POSTINC
	} dsad_mode_e;

	typedef enum logic [1:0] {
		PTR_X,
		PTR_Y,
		PTR_Z
	} dsad_ptr_e;

	typedef enum logic [2:0] {
		REGION_RF,
		REGION_STDIO,
		REGION_EXTIO,
		REGION_SRAM,
		REGION_NONE
	} dsad_region_e;

	typedef struct packed {
		logic        valid;
		dsad_kind_e  kind;
		dsad_mode_e  mode;
		dsad_ptr_e   ptr;
		logic [5:0]  disp;
		logic [15:0] addr;
		logic [5:0]  io_num;
		logic [2:0]  bit_sel;
		logic [7:0]  wdata;
	} dsad_req_s;

	typedef struct packed {
		logic        done;
		logic [7:0]  rdata;
		logic        skip;
		logic        refused;
	} dsad_resp_s;

endpackage

/* File: design/dsad_sram.sv */
// Internal data SRAM with a two-cycle access.
// Assumes the caller issues one access at a time and waits for the acknowledge.
`timescale 1ns/1ps
module dsad_sram
	import dsad_pkg::*;
#(
	parameter int unsigned DEPTH = SRAM_BYTES,
	parameter int unsigned AW    = SRAM_AW
)
(
	input  logic          i_core_clk,
	input  logic          i_reset_n,
	input  logic          i_en,
	input  logic          i_we,
	input  logic [AW-1:0] i_addr,
	input  logic [7:0]    i_wdata,
	output logic          o_ack,
	output logic [7:0]    o_rdata
);

	logic [7:0]    mem [DEPTH];
	logic          pend;
	logic          we_q;
	logic [AW-1:0] addr_q;
	logic [7:0]    wdata_q;

	generate
		if (DEPTH > (1 << AW))
		begin : g_bad_depth
			$error("SRAM depth does not fit the address width.");
		end
	endgenerate

	// The first cycle captures the command, the second performs it.
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			pend    <= 1'b0;
			we_q    <= 1'b0;
			addr_q  <= '0;
			wdata_q <= 8'h00;
		end
		else
		begin
			pend    <= i_en;
			we_q    <= i_we;
			addr_q  <= i_addr;
			wdata_q <= i_wdata;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (pend && we_q)
		begin
			mem[addr_q] <= wdata_q;
		end
	end

	// The answer stands during the second cycle so the caller can close the access at its end.
	assign o_ack   = pend;
	assign o_rdata = we_q ? wdata_q : mem[addr_q];

endmodule

/* File: design/dsad_top.sv */
// Data space address decoder: register file, I/O, scratch registers and SRAM.
// Assumes the execution unit holds a request for one cycle only while o_busy is low.
//
// Overview of operation
// - Data addresses 0x00-0x1F reach the working register file.
// - The next 64 data addresses reach the standard I/O registers.
// - The following 160 data addresses reach the extended I/O registers.
// - The following 512 data addresses reach the internal data SRAM.
// - Extended I/O 0x60-0xFF is reachable only by load and store.
// - I/O-in and I/O-out use I/O numbers 0x00 to 0x3F.
// - Load or store to standard I/O uses I/O number plus 0x20.
// - I/O numbers 0x00-0x1F accept single-bit set and clear.
// - Low I/O registers support skip tests on one selected bit.
// - Single-bit set or clear writes only the selected bit.
// - Some status flags clear when software writes a one to them.
// - Every internal SRAM access completes in two clock cycles.
// - Displacement mode adds up to 63 to the Y or Z pointer.
// - Pre-decrement and post-increment update the pointer in the register file.
// - Direct addressing reaches every location of the data space.
// - Program counter is 12 bits, addressing 4K words of 16 bits.
// - Three 8-bit scratch registers, read/write, reset to zero.
// - Data-space register accesses hit the same register file cells.
`timescale 1ns/1ps
module dsad_top
	import dsad_pkg::*;
#(
	parameter int unsigned SRAM_DEPTH = SRAM_BYTES,
	parameter int unsigned PC_BITS    = PC_W
)
(
	input  logic             i_core_clk,
	input  logic             i_reset_n,
	input  dsad_req_s        i_req,
	input  logic [7:0]       i_event_flags,
	input  logic             i_pc_load,
	input  logic [11:0]      i_pc_target,
	input  logic             i_pc_step,
	output dsad_resp_s       o_resp,
	output logic             o_busy,
	output logic [11:0]      o_pc,
	output logic [7:0]       o_flags,
	output logic [7:0]       o_scratch_zero,
	output logic [7:0]       o_scratch_one,
	output logic [7:0]       o_scratch_two
);

	typedef enum logic {
		ST_IDLE,
		ST_SRAM_WAIT
	} dsad_state_e;

	dsad_state_e  state;
	logic [7:0]   rf [RF_WORDS];
	logic [7:0]   scratch_reg_zero;
	logic [7:0]   scratch_reg_one;
	logic [7:0]   scratch_reg_two;
	logic [7:0]   event_flags;

	dsad_region_e region;
	logic         accept;
	logic [4:0]   ptr_lo;
	logic [15:0]  ptr_val;
	logic [15:0]  next_ptr;
	logic         ptr_update;
	logic [15:0]  eff_addr;
	logic [5:0]   io_num;
	logic         refused;
	logic         is_write;
	logic         is_bit_op;
	logic         is_skip;
	logic [7:0]   bit_mask;
	logic [7:0]   rd_val;
	logic [7:0]   wr_val;
	logic [7:0]   flag_clear;
	logic         sram_en;
	logic         sram_ack;
	logic [7:0]   sram_rdata;

	generate
		if (SRAM_DEPTH != SRAM_BYTES || PC_BITS != PC_W)
		begin : g_bad_params
			$error("SRAM depth and program counter width are fixed by the data map.");
		end
	endgenerate

	function automatic dsad_region_e region_of(input logic [15:0] a);
		if (a < STDIO_BASE)
			region_of = REGION_RF;
		else if (a < EXTIO_BASE)
			region_of = REGION_STDIO;
		else if (a < SRAM_BASE)
			region_of = REGION_EXTIO;
		else if (a < DATA_END)
			region_of = REGION_SRAM;
		else
			region_of = REGION_NONE;
	endfunction

	function automatic logic [4:0] ptr_base(input dsad_ptr_e p);
		case (p)
			PTR_X:   ptr_base = PTR_X_LO;
			PTR_Y:   ptr_base = PTR_Y_LO;
			PTR_Z:   ptr_base = PTR_Z_LO;
			default: ptr_base = PTR_Z_LO;
		endcase
	endfunction

	assign accept = i_req.valid && (state == ST_IDLE);

	// Effective address generation for every instruction family.
	always_comb
	begin
		ptr_lo     = ptr_base(i_req.ptr);
		ptr_val    = {rf[ptr_lo + 5'd1], rf[ptr_lo]};
		next_ptr   = ptr_val;
		ptr_update = 1'b0;
		refused    = 1'b0;
		eff_addr   = i_req.addr;
		io_num     = i_req.io_num;
		case (i_req.kind)
			KIND_IO_IN, KIND_IO_OUT:
			begin
				eff_addr = {10'h000, i_req.io_num} + IO_DATA_OFS;
			end
			KIND_BIT_SET, KIND_BIT_CLEAR, KIND_SKIP_IF_SET, KIND_SKIP_IF_CLEAR:
			begin
				refused  = (i_req.io_num > BIT_IO_LAST);
				eff_addr = {10'h000, i_req.io_num} + IO_DATA_OFS;
			end
			default:
			begin
				case (i_req.mode)
					MODE_INDIRECT:
						eff_addr = ptr_val;
					MODE_DISP:
					begin
						refused  = (i_req.ptr == PTR_X);
						eff_addr = ptr_val + {10'h000, i_req.disp};
					end
					MODE_PREDEC:
					begin
						next_ptr   = ptr_val - 16'h0001;
						eff_addr   = next_ptr;
						ptr_update = 1'b1;
					end
					MODE_POSTINC:
					begin
						next_ptr   = ptr_val + 16'h0001;
						eff_addr   = ptr_val;
						ptr_update = 1'b1;
					end
					default:
						eff_addr = i_req.addr;
				endcase
			end
		endcase
		if (i_req.kind != KIND_LOAD && i_req.kind != KIND_STORE)
		begin
			io_num = i_req.io_num;
		end
		else
		begin
			io_num = 6'(eff_addr - IO_DATA_OFS);
		end
	end

	assign region    = region_of(eff_addr);
	assign is_write  = (i_req.kind == KIND_STORE) || (i_req.kind == KIND_IO_OUT);
	assign is_bit_op = (i_req.kind == KIND_BIT_SET) || (i_req.kind == KIND_BIT_CLEAR);
	assign is_skip   = (i_req.kind == KIND_SKIP_IF_SET) || (i_req.kind == KIND_SKIP_IF_CLEAR);
	assign bit_mask  = 8'h01 << i_req.bit_sel;
	assign sram_en   = accept && !refused && (region_of(eff_addr) == REGION_SRAM);

	// Read side of the register file and the I/O map.
	always_comb
	begin
		rd_val = 8'h00;
		case (region)
			REGION_RF:
				rd_val = rf[eff_addr[4:0]];
			REGION_STDIO:
			begin
				case (io_num)
					IO_SCRATCH_ZERO: rd_val = scratch_reg_zero;
					IO_SCRATCH_ONE:  rd_val = scratch_reg_one;
					IO_SCRATCH_TWO:  rd_val = scratch_reg_two;
					IO_EVENT_FLAGS:  rd_val = event_flags;
					default:         rd_val = 8'h00;
				endcase
			end
			REGION_EXTIO:
				rd_val = 8'h00;
			default:
				rd_val = 8'h00;
		endcase
	end

	// Value a store or a single-bit operation leaves in a plain register.
	always_comb
	begin
		wr_val     = i_req.wdata;
		flag_clear = 8'h00;
		if (is_bit_op)
		begin
			if (i_req.kind == KIND_BIT_SET)
				wr_val = rd_val | bit_mask;
			else
				wr_val = rd_val & ~bit_mask;
		end
		if (accept && !refused && region == REGION_STDIO && io_num == IO_EVENT_FLAGS)
		begin
			if (is_write)
				flag_clear = i_req.wdata;
			else if (i_req.kind == KIND_BIT_SET)
				flag_clear = bit_mask;
		end
	end

	// Register file: data-space stores and pointer write-back share the cells.
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			for (int i = 0; i < RF_WORDS; i++)
			begin
				rf[i] <= RF_RESET;
			end
		end
		else if (accept && !refused)
		begin
			if (is_write && region == REGION_RF)
			begin
				rf[eff_addr[4:0]] <= i_req.wdata;
			end
			if (ptr_update)
			begin
				rf[ptr_lo]         <= next_ptr[7:0];
				rf[ptr_lo + 5'd1]  <= next_ptr[15:8];
			end
		end
	end

	// Scratch registers take full-byte writes or a single modified bit.
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			scratch_reg_zero <= SCRATCH_RESET;
			scratch_reg_one  <= SCRATCH_RESET;
			scratch_reg_two  <= SCRATCH_RESET;
		end
		else if (accept && !refused && region == REGION_STDIO && (is_write || is_bit_op))
		begin
			case (io_num)
				IO_SCRATCH_ZERO: scratch_reg_zero <= wr_val;
				IO_SCRATCH_ONE:  scratch_reg_one  <= wr_val;
				IO_SCRATCH_TWO:  scratch_reg_two  <= wr_val;
				default:         ;
			endcase
		end
	end

	// Event flags: a new event in the clearing cycle survives the clear.
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			event_flags <= FLAGS_RESET;
		end
		else
		begin
			event_flags <= (event_flags & ~flag_clear) | i_event_flags;
		end
	end

	// Request sequencing and the answer to the execution unit.
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state          <= ST_IDLE;
			o_busy         <= 1'b0;
			o_resp         <= '0;
		end
		else
		begin
			o_resp.done <= 1'b0;
			case (state)
				ST_IDLE:
				begin
					if (accept && sram_en)
					begin
						state  <= ST_SRAM_WAIT;
						o_busy <= 1'b1;
					end
					else if (accept)
					begin
						o_resp.done    <= 1'b1;
						o_resp.refused <= refused;
						o_resp.rdata   <= refused ? 8'h00 : rd_val;
						o_resp.skip    <= !refused && is_skip &&
							((|(rd_val & bit_mask)) == (i_req.kind == KIND_SKIP_IF_SET));
					end
				end
				ST_SRAM_WAIT:
				begin
					if (sram_ack)
					begin
						state          <= ST_IDLE;
						o_busy         <= 1'b0;
						o_resp.done    <= 1'b1;
						o_resp.refused <= 1'b0;
						o_resp.skip    <= 1'b0;
						o_resp.rdata   <= sram_rdata;
					end
				end
				default:
				begin
					state  <= ST_IDLE;
					o_busy <= 1'b0;
				end
			endcase
		end
	end

	// Program counter addressing 4K words of program memory.
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_pc <= PC_RESET;
		end
		else if (i_pc_load)
		begin
			o_pc <= i_pc_target;
		end
		else if (i_pc_step)
		begin
			o_pc <= o_pc + 12'h001;
		end
	end

	// Mirrors of the software-visible registers for the surrounding logic.
	always_ff @(posedge i_core_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_flags        <= FLAGS_RESET;
			o_scratch_zero <= SCRATCH_RESET;
			o_scratch_one  <= SCRATCH_RESET;
			o_scratch_two  <= SCRATCH_RESET;
		end
		else
		begin
			o_flags        <= event_flags;
			o_scratch_zero <= scratch_reg_zero;
			o_scratch_one  <= scratch_reg_one;
			o_scratch_two  <= scratch_reg_two;
		end
	end

	dsad_sram #(
		.DEPTH (SRAM_BYTES),
		.AW    (SRAM_AW)
	) u_sram (
		.i_core_clk (i_core_clk),
		.i_reset_n  (i_reset_n),
		.i_en       (sram_en),
		.i_we       (is_write),
		.i_addr     (SRAM_AW'(eff_addr - SRAM_BASE)),
		.i_wdata    (i_req.wdata),
		.o_ack      (sram_ack),
		.o_rdata    (sram_rdata)
	);

endmodule

/* File: testbench/dsad_chk.sv */
// Checker for the decoder top: answer timing, refusals and program counter.
// Sees only the ports of dsad_top and is bound into every instance of it.
`timescale 1ns/1ps
module dsad_chk
	import dsad_pkg::*;
(
	input logic        i_core_clk,
	input logic        i_reset_n,
	input dsad_req_s   i_req,
	input logic        i_pc_load,
	input logic [11:0] i_pc_target,
	input logic        i_pc_step,
	input dsad_resp_s  o_resp,
	input logic        o_busy,
	input logic [11:0] o_pc
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	logic take;
	logic ls;
	logic sram;
	assign take = i_req.valid && !o_busy;
	assign ls = take && i_req.mode == MODE_DIRECT
		&& (i_req.kind == KIND_LOAD || i_req.kind == KIND_STORE);
	assign sram = ls && i_req.addr >= SRAM_BASE && i_req.addr < DATA_END;
	a_sram_two_cycle: assert property (sram |=> !o_resp.done ##1 o_resp.done)
		else $error("sram answer not two cycles");
	a_sram_busy_window: assert property (sram |=> o_busy ##1 !o_busy)
		else $error("busy window wrong");
	a_busy_no_done: assert property (o_busy |-> !o_resp.done)
		else $error("done while busy");
	a_reg_one_cycle: assert property (ls && i_req.addr < SRAM_BASE |=> o_resp.done && !o_busy)
		else $error("register answer late");
	a_sram_store_echo: assert property (sram && i_req.kind == KIND_STORE
		|-> ##2 o_resp.rdata == $past(i_req.wdata, 2)) else $error("store echo wrong");
	a_extio_reads_zero: assert property (ls && i_req.kind == KIND_LOAD
		&& i_req.addr >= EXTIO_BASE && i_req.addr < SRAM_BASE |=> o_resp.rdata == 8'h00)
		else $error("extended io read not zero");
	a_bit_high_refused: assert property (take && i_req.kind >= KIND_BIT_SET
		&& i_req.io_num > BIT_IO_LAST |=> o_resp.done && o_resp.refused)
		else $error("high bit access not refused");
	a_disp_x_refused: assert property (take && i_req.mode == MODE_DISP && i_req.ptr == PTR_X
		|=> o_resp.refused && o_resp.rdata == 8'h00) else $error("x displacement not refused");
	a_pc_load_value: assert property (i_pc_load |=> o_pc == $past(i_pc_target))
		else $error("pc load wrong");
	a_pc_step_wrap: assert property (i_pc_step && !i_pc_load |=> o_pc == $past(o_pc) + 12'h001)
		else $error("pc step wrong");
	c_sram: cover property (sram);
	c_skip: cover property (take && i_req.kind == KIND_SKIP_IF_SET);
	c_pc_load: cover property (i_pc_load);
endmodule

bind dsad_top dsad_chk u_chk (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_req(i_req),
	.i_pc_load(i_pc_load), .i_pc_target(i_pc_target), .i_pc_step(i_pc_step),
	.o_resp(o_resp), .o_busy(o_busy), .o_pc(o_pc));

/* File: testbench/dsad_cpu_model.sv */
// Model of the execution unit: issues one request at a time and waits for its answer.
// Assumes the decoder answers within three cycles of taking a request.
`timescale 1ns/1ps
module dsad_cpu_model
	import dsad_pkg::*;
(
	input  logic       i_core_clk,
	input  dsad_resp_s i_resp,
	output dsad_req_s  o_req,
	output logic       o_lost
);
	initial o_req = '0;
	initial o_lost = 1'b0;
	task automatic xfer(input dsad_req_s r, output dsad_resp_s s);
		dsad_req_s t;
		t = ~r;
		t.valid = 1'b0;
		s = '0;
		@(posedge i_core_clk);
		o_req <= r;
		@(posedge i_core_clk);
		// Idle fields are scrambled so a stale value is never mistaken for a live one.
		o_req <= t;
		repeat (3)
		begin
			#1;
			if (i_resp.done)
			begin
				s = i_resp;
				return;
			end
			@(posedge i_core_clk);
		end
		o_lost = 1'b1;
	endtask
endmodule

/* File: testbench/data_space_address_decoder_test.sv */
// Self-checking bench for the decoder: directed corners plus seeded random traffic.
// Assumes the execution-unit model finishes each transfer before the next begins.
`timescale 1ns/1ps
module data_space_address_decoder_test;
	import dsad_pkg::*;
	logic        i_core_clk = 1'b0;
	logic        i_reset_n = 1'b0;
	logic [7:0]  i_event_flags = 8'h00;
	logic        i_pc_load = 1'b0;
	logic [11:0] i_pc_target = 12'h000;
	logic        i_pc_step = 1'b0;
	dsad_req_s   req;
	dsad_resp_s  resp;
	dsad_resp_s  got;
	logic        o_busy;
	logic        lost;
	logic [11:0] o_pc;
	logic [7:0]  o_flags;
	logic [7:0]  s0;
	logic [7:0]  s1;
	logic [7:0]  s2;
	logic [7:0]  mem [0:1023];
	bit          wr [0:1023];
	int          miscompares = 0;
	int          n_tests = 0;
	logic [31:0] seed = 32'h0000_a056;
	logic [31:0] x;
	logic [15:0] a;

	always #50 i_core_clk = ~i_core_clk;

	dsad_top u_dut (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_req(req),
		.i_event_flags(i_event_flags), .i_pc_load(i_pc_load), .i_pc_target(i_pc_target),
		.i_pc_step(i_pc_step), .o_resp(resp), .o_busy(o_busy), .o_pc(o_pc),
		.o_flags(o_flags), .o_scratch_zero(s0), .o_scratch_one(s1), .o_scratch_two(s2));
	dsad_cpu_model u_cpu (.i_core_clk(i_core_clk), .i_resp(resp), .o_req(req), .o_lost(lost));

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic wable(input logic [15:0] v);
		return v < STDIO_BASE || (v >= 16'h003c && v <= 16'h003e)
			|| (v >= SRAM_BASE && v < DATA_END);
	endfunction

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [11:0] e, input logic [11:0] g);
		n_tests++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic op(input dsad_kind_e k, input dsad_mode_e m, input dsad_ptr_e p,
		input logic [5:0] d, input logic [15:0] v, input logic [7:0] w);
		dsad_req_s r;
		r = '{1'b1, k, m, p, d, v, v[5:0], d[2:0], w};
		u_cpu.xfer(r, got);
		chk("answered", 12'h000, 12'(lost));
	endtask

	task automatic ld(input logic [15:0] v);
		op(KIND_LOAD, MODE_DIRECT, PTR_X, 6'h00, v, 8'h00);
		if (v < SRAM_BASE || v >= DATA_END || wr[v[9:0]])
			chk("load", 12'(mem[v[9:0]]), 12'(got.rdata));
	endtask

	task automatic st(input logic [15:0] v, input logic [7:0] w);
		op(KIND_STORE, MODE_DIRECT, PTR_X, 6'h00, v, w);
		if (v < SRAM_BASE)
			chk("store old", 12'(mem[v[9:0]]), 12'(got.rdata));
		mem[v[9:0]] = w;
		wr[v[9:0]] = 1'b1;
	endtask

	task automatic io(input dsad_kind_e k, input logic [2:0] b, input logic [5:0] n,
		input logic [7:0] w);
		op(k, MODE_DIRECT, PTR_X, {3'h0, b}, {10'h000, n}, w);
	endtask

	task automatic pc(input logic [11:0] t, input int n);
		@(posedge i_core_clk);
		i_pc_target <= t;
		i_pc_load <= 1'b1;
		@(posedge i_core_clk);
		i_pc_load <= 1'b0;
		i_pc_step <= 1'b1;
		repeat (n) @(posedge i_core_clk);
		i_pc_step <= 1'b0;
		#1;
		chk("pc", t + 12'(n), o_pc);
	endtask

	initial
	begin
		#(100 * 20000);
		miscompares++;
		give_verdict();
	end

	initial
	begin
		foreach (mem[i])
			mem[i] = 8'h00;
		repeat (5) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		#1;
		chk("reset", 12'h000, 12'(s0 | s1 | s2) | o_pc);
		st(16'h001e, 8'h20);
		st(16'h001f, 8'h01);
		op(KIND_STORE, MODE_POSTINC, PTR_Z, 6'h00, 16'h0000, 8'h5a);
		mem[10'h120] = 8'h5a;
		wr[10'h120] = 1'b1;
		mem[10'h01e] = 8'h21;
		ld(16'h001e);
		ld(16'h0120);
		st(16'h0160, 8'hc3);
		op(KIND_LOAD, MODE_DISP, PTR_Z, DISP_MAX, 16'h0000, 8'h00);
		chk("disp", 12'h0c3, 12'(got.rdata));
		op(KIND_LOAD, MODE_PREDEC, PTR_Z, 6'h00, 16'h0000, 8'h00);
		chk("predec", 12'h05a, 12'(got.rdata));
		mem[10'h01e] = 8'h20;
		ld(16'h001e);
		op(KIND_LOAD, MODE_DISP, PTR_X, 6'h01, 16'h0000, 8'h00);
		chk("x disp", 12'h001, 12'(got.refused));
		io(KIND_BIT_SET, 3'h0, 6'h20, 8'h00);
		chk("bit high", 12'h001, 12'(got.refused));
		io(KIND_IO_OUT, 3'h0, IO_SCRATCH_TWO, 8'h77);
		mem[10'h03e] = 8'h77;
		ld(16'h003e);
		io(KIND_BIT_SET, 3'h6, IO_SCRATCH_ONE, 8'h00);
		io(KIND_IO_IN, 3'h0, IO_SCRATCH_ONE, 8'h00);
		chk("bit set", 12'h040, 12'(got.rdata));
		io(KIND_BIT_CLEAR, 3'h6, IO_SCRATCH_ONE, 8'h00);
		io(KIND_IO_IN, 3'h0, IO_SCRATCH_ONE, 8'h00);
		chk("bit clear", 12'h000, 12'(got.rdata));
		@(posedge i_core_clk) i_event_flags <= 8'ha5;
		@(posedge i_core_clk) i_event_flags <= 8'h00;
		io(KIND_SKIP_IF_SET, 3'h2, IO_EVENT_FLAGS, 8'h00);
		chk("skip set", 12'h001, 12'(got.skip));
		io(KIND_SKIP_IF_CLEAR, 3'h2, IO_EVENT_FLAGS, 8'h00);
		chk("skip clear", 12'h000, 12'(got.skip));
		io(KIND_BIT_SET, 3'h0, IO_EVENT_FLAGS, 8'h00);
		io(KIND_BIT_CLEAR, 3'h2, IO_EVENT_FLAGS, 8'h00);
		io(KIND_IO_IN, 3'h0, IO_EVENT_FLAGS, 8'h00);
		chk("flags bit", 12'h0a4, 12'(got.rdata));
		io(KIND_IO_OUT, 3'h0, IO_EVENT_FLAGS, 8'h80);
		io(KIND_IO_IN, 3'h0, IO_EVENT_FLAGS, 8'h00);
		chk("flags w1c", 12'h024, 12'(got.rdata));
		mem[10'h03f] = 8'h24;
		st(16'h003f, 8'h24);
		mem[10'h03f] = 8'h00;
		repeat (60)
		begin
			x = rnd();
			a = {6'h00, x[9:0]};
			if (x[12] && wable(a))
				st(a, x[23:16]);
			else if (x[13] && a >= STDIO_BASE && a < EXTIO_BASE)
			begin
				io(KIND_IO_IN, 3'h0, 6'(a - IO_DATA_OFS), 8'h00);
				chk("in", 12'(mem[a[9:0]]), 12'(got.rdata));
			end
			else
				ld(a);
		end
		pc(12'(rnd()), 3);
		pc(12'hfff, 1);
		repeat (3) @(posedge i_core_clk);
		chk("mirror zero", 12'(mem[10'h03c]), 12'(s0));
		chk("mirror one", 12'(mem[10'h03d]), 12'(s1));
		chk("mirror two", 12'(mem[10'h03e]), 12'(s2));
		chk("flags out", 12'h000, 12'(o_flags));
		give_verdict();
	end
endmodule
